/* File: verilog/dps_sequencer.sv */
// Digital positioning sequencer: registers, homing, cycling, ramp and completion
// Overview of operation
// R1 - Bit0 relative only; absolute kept inert
// R2 - Bit1 terminal-started or automatic cycles
// R3 - Bit2 repetitive honoured only when automatic
// R4 - Bit3 position-type target, not when continuous
// R5 - Bit4 home once or every run
// R6 - Bit5 real-time or single home calibration
// R7 - Bit6 completion timed or held on
// R8 - Bit7 optional initial move, terminal cycling
// R9 - Bit8 enable pulse or level; auto always
// R10 - Bit9 target from parameter or fieldbus
// R11 - Bit10 save encoder count at power loss
// R12 - Bits 11,12 reserved; mode resets zero
// R13 - Travel equals target times numerator over denominator
// R14 - Speed source: digital, three analogs, two pulses
// R15 - Digital speed is permille of maximum frequency
// R16 - Acceleration time spans zero to maximum
// R17 - Deceleration time spans maximum to zero
// R18 - Arrival hold wait before next cycle
// R19 - Home search at programmed home speed
// R20 - Completion hold also times orientation signal
// R21 - Completion after deviation below range long enough
// R22 - Gear terms are 1 to 65535
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"
module dps_sequencer #(
  parameter int          BRAKE_GAIN = 16,
  parameter logic [15:0] CREEP      = 16'h0001
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        run_cmd,
  input  wire logic        enable_pin,
  input  wire logic        home_pin,
  input  wire logic        power_fail_pin,
  input  wire logic [31:0] enc_count,
  input  wire logic [15:0] bus_target,
  input  wire logic [15:0] analog_input_one,
  input  wire logic [15:0] analog_input_two,
  input  wire logic [15:0] analog_input_three,
  input  wire logic [15:0] fast_pulse_input_a,
  input  wire logic [15:0] fast_pulse_input_b,
  input  wire logic        orient_done,
  output logic      [15:0] freq_cmd,
  output logic             dir_rev,
  output logic             motor_run,
  output logic             positioning_done,
  output logic             orient_done_out,
  output logic             home_found,
  output logic             save_req,
  output logic      [31:0] saved_count
);
  logic [15:0] positioning_mode_word_reg, digital_target_value_reg, gear_numerator_reg, gear_denominator_reg;
  logic [2:0]  speed_source_select_reg;
  logic [15:0] digital_positioning_speed_reg, positioning_accel_time_reg, positioning_decel_time_reg;
  logic [15:0] arrival_hold_time_reg, home_search_speed_reg, completion_hold_time_reg;
  logic [15:0] completion_range_reg, completion_detect_time_reg, max_output_frequency_reg;
  logic [2:0]  s1_reg, s2_reg, s3_reg;
  logic [`DPS_TICK_W-1:0] tick_cnt_reg;
  logic [3:0]  sub_cnt_reg, ms_cnt_reg;
  logic        tick, tick100, tick_ms;
  dps_pkg::dps_state_t state_reg;
  logic [31:0] home_ref_reg, goal_reg, origin_reg;
  logic        phase_reg, first_reg, load;
  logic [15:0] ramp_reg, step_cnt_reg, wait_cnt_reg, cpl_cnt_reg, ori_cnt_reg;
  logic [15:0] mw, target_sel, sp_raw, sp, ramp_target;
  logic [31:0] pos, travel, dev, absdev, goal_new, brake, base_lo, freq_wide;
  logic        auto_mode, rep_mode, posval, en_s, en_rise, home_rise, pf_rise, trigger, near, complete;

  assign mw = positioning_mode_word_reg;
  // Mode decode
  assign auto_mode = mw[`DPS_B_AUTO];
  // R3 - repetitive needs automatic
  assign rep_mode  = mw[`DPS_B_REP] & auto_mode;
  // R4 - position type excluded in continuous
  assign posval    = mw[`DPS_B_POSVAL] & rep_mode;

  // Only the second and third stages are looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
    end else if (ce) begin
      s1_reg <= {power_fail_pin, home_pin, enable_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign en_s      = s2_reg[0];
  assign en_rise   = s2_reg[0] & ~s3_reg[0];
  assign home_rise = s2_reg[1] & ~s3_reg[1];
  assign pf_rise   = s2_reg[2] & ~s3_reg[2];

  // Time base: 10 us, 100 us and 1 ms ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      sub_cnt_reg  <= 4'h0;
      ms_cnt_reg   <= 4'h0;
    end else if (ce) begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
      if (tick)
        sub_cnt_reg <= tick100 ? 4'h0 : sub_cnt_reg + 4'h1;
      if (tick100)
        ms_cnt_reg <= tick_ms ? 4'h0 : ms_cnt_reg + 4'h1;
    end
  end
  assign tick    = (tick_cnt_reg == `DPS_TICK_W'(`DPS_TICK_CYC - 1));
  assign tick100 = tick & (sub_cnt_reg == `DPS_SUB_DIV - 4'h1);
  assign tick_ms = tick100 & (ms_cnt_reg == `DPS_SUB_DIV - 4'h1);

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      // R12 - mode word resets to zero
      positioning_mode_word_reg     <= `DPS_RST_MODE;
      digital_target_value_reg      <= `DPS_RST_TARGET;
      gear_numerator_reg            <= `DPS_RST_GEAR;
      gear_denominator_reg          <= `DPS_RST_GEAR;
      speed_source_select_reg       <= `DPS_RST_SPSEL;
      digital_positioning_speed_reg <= `DPS_RST_DSPEED;
      positioning_accel_time_reg    <= `DPS_RST_RAMP_T;
      positioning_decel_time_reg    <= `DPS_RST_RAMP_T;
      arrival_hold_time_reg         <= `DPS_RST_ARRIVE;
      home_search_speed_reg         <= `DPS_RST_HOMESPD;
      completion_hold_time_reg      <= `DPS_RST_CPLHOLD;
      completion_range_reg          <= `DPS_RST_RANGE;
      completion_detect_time_reg    <= `DPS_RST_DETECT;
      max_output_frequency_reg      <= `DPS_RST_FMAX;
    end else if (ce && wr) begin
      unique case (addr)
        // R12 - reserved bits never stored
        `DPS_A_MODE:     positioning_mode_word_reg <= wdata & `DPS_MODE_MASK;
        `DPS_A_TARGET:   digital_target_value_reg <= wdata;
        // R22 - zero lifted to one
        `DPS_A_GEAR_NUM: gear_numerator_reg <= (wdata == 16'h0000) ? 16'h0001 : wdata;
        `DPS_A_GEAR_DEN: gear_denominator_reg <= (wdata == 16'h0000) ? 16'h0001 : wdata;
        `DPS_A_SPSEL:    if (wdata[2:0] <= `DPS_SPSEL_MAX) speed_source_select_reg <= wdata[2:0];
        // R15 - clamp at full scale
        `DPS_A_DSPEED:   digital_positioning_speed_reg <= (wdata > `DPS_FULL_SCALE) ? `DPS_FULL_SCALE : wdata;
        // R16 - zero lifted to 0.01 s
        `DPS_A_ACCEL:    positioning_accel_time_reg <= (wdata == 16'h0000) ? 16'h0001 : wdata;
        // R17 - zero lifted to 0.01 s
        `DPS_A_DECEL:    positioning_decel_time_reg <= (wdata == 16'h0000) ? 16'h0001 : wdata;
        `DPS_A_ARRIVE:   arrival_hold_time_reg <= wdata;
        `DPS_A_HOMESPD:  home_search_speed_reg <= wdata;
        `DPS_A_CPLHOLD:  completion_hold_time_reg <= wdata;
        `DPS_A_RANGE:    completion_range_reg <= wdata;
        `DPS_A_DETECT:   completion_detect_time_reg <= wdata;
        `DPS_A_FMAX:     max_output_frequency_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Register reads, answered in the next cycle only
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (rd) begin
        unique case (addr)
          `DPS_A_MODE:     rdata <= positioning_mode_word_reg;
          `DPS_A_TARGET:   rdata <= digital_target_value_reg;
          `DPS_A_GEAR_NUM: rdata <= gear_numerator_reg;
          `DPS_A_GEAR_DEN: rdata <= gear_denominator_reg;
          `DPS_A_SPSEL:    rdata <= {13'h0000, speed_source_select_reg};
          `DPS_A_DSPEED:   rdata <= digital_positioning_speed_reg;
          `DPS_A_ACCEL:    rdata <= positioning_accel_time_reg;
          `DPS_A_DECEL:    rdata <= positioning_decel_time_reg;
          `DPS_A_ARRIVE:   rdata <= arrival_hold_time_reg;
          `DPS_A_HOMESPD:  rdata <= home_search_speed_reg;
          `DPS_A_CPLHOLD:  rdata <= completion_hold_time_reg;
          `DPS_A_RANGE:    rdata <= completion_range_reg;
          `DPS_A_DETECT:   rdata <= completion_detect_time_reg;
          `DPS_A_FMAX:     rdata <= max_output_frequency_reg;
          `DPS_A_POS_LO:   rdata <= pos[15:0];
          `DPS_A_POS_HI:   rdata <= pos[31:16];
          `DPS_A_STATUS:   rdata <= {9'h000, phase_reg, home_found, positioning_done, 1'b0, state_reg};
          default:         ;
        endcase
      end
    end
  end

  // R10 - target source
  assign target_sel = mw[`DPS_B_SRC_BUS] ? bus_target : digital_target_value_reg;
  // R13 - electronic gear
  assign travel = (32'(target_sel) * 32'(gear_numerator_reg)) / 32'(gear_denominator_reg);
  // R1 - count relative to home reference
  assign pos    = enc_count - home_ref_reg;
  assign dev    = goal_reg - pos;
  assign absdev = dev[31] ? (32'h0 - dev) : dev;
  assign near   = absdev < 32'(completion_range_reg);

  // Next goal: repetitive swings between two ends, continuous keeps stepping
  assign base_lo = posval ? 32'h0 : origin_reg;
  always_comb begin
    goal_new = goal_reg + travel;
    if (rep_mode)
      goal_new = phase_reg ? base_lo : base_lo + travel;
  end

  // R9 - enable as level or pulse
  assign trigger = auto_mode | (mw[`DPS_B_EN_LEVEL] ? en_s : en_rise);
  // R21 - deviation held inside range
  assign complete = (state_reg == dps_pkg::DPS_SETTLE) && near && tick100
                    && (wait_cnt_reg >= completion_detect_time_reg);

  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= dps_pkg::DPS_IDLE;
      home_ref_reg <= 32'h0;
      goal_reg     <= 32'h0;
      origin_reg   <= 32'h0;
      phase_reg    <= 1'b0;
      first_reg    <= 1'b0;
      home_found   <= 1'b0;
      wait_cnt_reg <= 16'h0000;
    end else if (ce) begin
      if (load) begin
        goal_reg  <= goal_new;
        phase_reg <= rep_mode & ~phase_reg;
      end
      // R6 - real-time recalibration
      if (home_rise && home_found && !mw[`DPS_B_CAL_ONCE] && state_reg != dps_pkg::DPS_HOME)
        home_ref_reg <= enc_count;
      unique case (state_reg)
        dps_pkg::DPS_IDLE: begin
          phase_reg <= 1'b0;
          if (run_cmd) begin
            first_reg <= 1'b1;
            // R5 - home once or every run
            if (mw[`DPS_B_HOME_EACH] || !home_found)
              state_reg <= dps_pkg::DPS_HOME;
            else begin
              origin_reg <= pos;
              goal_reg   <= pos;
              state_reg  <= dps_pkg::DPS_WAIT;
            end
          end
        end
        dps_pkg::DPS_HOME: begin
          if (home_rise) begin
            home_ref_reg <= enc_count;
            home_found   <= 1'b1;
            origin_reg   <= 32'h0;
            goal_reg     <= 32'h0;
            state_reg    <= dps_pkg::DPS_WAIT;
          end
        end
        dps_pkg::DPS_WAIT: begin
          first_reg <= 1'b0;
          if (load)
            state_reg <= dps_pkg::DPS_MOVE;
        end
        dps_pkg::DPS_MOVE: begin
          wait_cnt_reg <= 16'h0000;
          if (near)
            state_reg <= dps_pkg::DPS_SETTLE;
        end
        dps_pkg::DPS_SETTLE: begin
          if (!near) begin
            state_reg <= dps_pkg::DPS_MOVE;
          end else if (complete) begin
            wait_cnt_reg <= 16'h0000;
            state_reg    <= dps_pkg::DPS_HOLD;
          end else if (tick100) begin
            wait_cnt_reg <= wait_cnt_reg + 16'h0001;
          end
        end
        dps_pkg::DPS_HOLD: begin
          // R18 - arrival hold
          if (tick_ms && wait_cnt_reg >= arrival_hold_time_reg)
            state_reg <= load ? dps_pkg::DPS_MOVE : dps_pkg::DPS_WAIT;
          else if (tick_ms)
            wait_cnt_reg <= wait_cnt_reg + 16'h0001;
        end
        default: state_reg <= dps_pkg::DPS_IDLE;
      endcase
      if (!run_cmd)
        state_reg <= dps_pkg::DPS_IDLE;
    end
  end

  // Goal load on a start condition
  always_comb begin
    load = 1'b0;
    if (run_cmd && state_reg == dps_pkg::DPS_WAIT)
      // R8 - initial move without trigger
      load = trigger | (first_reg & mw[`DPS_B_INIT_MOVE] & ~auto_mode);
    // R2 - automatic cycling restarts itself
    if (run_cmd && state_reg == dps_pkg::DPS_HOLD && tick_ms && wait_cnt_reg >= arrival_hold_time_reg)
      load = auto_mode | (mw[`DPS_B_EN_LEVEL] & en_s);
  end

  // R14 - speed source
  always_comb begin
    unique case (speed_source_select_reg)
      3'h1:    sp_raw = analog_input_one;
      3'h2:    sp_raw = analog_input_two;
      3'h3:    sp_raw = analog_input_three;
      3'h4:    sp_raw = fast_pulse_input_a;
      3'h5:    sp_raw = fast_pulse_input_b;
      default: sp_raw = digital_positioning_speed_reg;
    endcase
  end
  assign sp    = (sp_raw > `DPS_FULL_SCALE) ? `DPS_FULL_SCALE : sp_raw;
  // Crude stopping estimate; no distance planning, so large gains overshoot less
  assign brake = 32'(ramp_reg) * 32'(BRAKE_GAIN);
  assign ramp_target = (state_reg != dps_pkg::DPS_MOVE) ? 16'h0000 : (absdev <= brake) ? CREEP : sp;

  // Ramp: one permille per accel or decel time in 10 us ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_reg     <= 16'h0000;
      step_cnt_reg <= 16'h0000;
    end else if (ce && tick) begin
      if (ramp_reg == ramp_target) begin
        step_cnt_reg <= 16'h0000;
      // R16 - acceleration step
      end else if (ramp_reg < ramp_target) begin
        if (step_cnt_reg + 16'h0001 >= positioning_accel_time_reg) begin
          step_cnt_reg <= 16'h0000;
          ramp_reg     <= ramp_reg + 16'h0001;
        end else
          step_cnt_reg <= step_cnt_reg + 16'h0001;
      // R17 - deceleration step
      end else if (step_cnt_reg + 16'h0001 >= positioning_decel_time_reg) begin
        step_cnt_reg <= 16'h0000;
        ramp_reg     <= ramp_reg - 16'h0001;
      end else
        step_cnt_reg <= step_cnt_reg + 16'h0001;
    end
  end

  assign freq_wide = (32'(ramp_reg) * 32'(max_output_frequency_reg)) / 32'(`DPS_FULL_SCALE);
  // Drive outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_cmd  <= 16'h0000;
      dir_rev   <= 1'b0;
      motor_run <= 1'b0;
    end else if (ce) begin
      if (state_reg == dps_pkg::DPS_HOME) begin
        // R19 - home search speed, reverse
        freq_cmd  <= home_search_speed_reg;
        dir_rev   <= 1'b1;
        motor_run <= 1'b1;
      end else begin
        freq_cmd  <= freq_wide[15:0];
        dir_rev   <= dev[31];
        motor_run <= (ramp_reg != 16'h0000);
      end
    end
  end

  // Completion output
  always_ff @(posedge clk) begin
    if (rst) begin
      positioning_done <= 1'b0;
      cpl_cnt_reg      <= 16'h0000;
    end else if (ce) begin
      if (complete) begin
        positioning_done <= 1'b1;
        cpl_cnt_reg      <= 16'h0000;
      end else if (load || !run_cmd) begin
        positioning_done <= 1'b0;
      // R7 - timed unless held
      end else if (positioning_done && !mw[`DPS_B_CPL_LEVEL] && tick_ms) begin
        if (cpl_cnt_reg >= completion_hold_time_reg)
          positioning_done <= 1'b0;
        else
          cpl_cnt_reg <= cpl_cnt_reg + 16'h0001;
      end
    end
  end

  // R20 - orientation completion timed too
  always_ff @(posedge clk) begin
    if (rst) begin
      orient_done_out <= 1'b0;
      ori_cnt_reg     <= 16'h0000;
    end else if (ce) begin
      if (orient_done) begin
        orient_done_out <= 1'b1;
        ori_cnt_reg     <= 16'h0000;
      end else if (orient_done_out && tick_ms) begin
        if (ori_cnt_reg >= completion_hold_time_reg)
          orient_done_out <= 1'b0;
        else
          ori_cnt_reg <= ori_cnt_reg + 16'h0001;
      end
    end
  end

  // R11 - save count at power loss
  always_ff @(posedge clk) begin
    if (rst) begin
      save_req    <= 1'b0;
      saved_count <= 32'h0;
    end else if (ce) begin
      save_req <= pf_rise & mw[`DPS_B_SAVE_CNT];
      if (pf_rise && mw[`DPS_B_SAVE_CNT])
        saved_count <= enc_count;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/dps_params.svh */
// Constants of the digital positioning sequencer
`ifndef DPS_PARAMS_SVH
`define DPS_PARAMS_SVH
`define DPS_CLK_PERIOD_NS 8
`define DPS_TICK_NS       10000
`define DPS_TICK_CYC      (`DPS_TICK_NS / `DPS_CLK_PERIOD_NS)
`define DPS_TICK_W        12
`define DPS_SUB_DIV       4'hA
`define DPS_FULL_SCALE    16'h03E8
`define DPS_SPSEL_MAX     3'h5
`define DPS_MODE_MASK     16'h07FF
`define DPS_A_MODE        8'h00
`define DPS_A_TARGET      8'h04
`define DPS_A_GEAR_NUM    8'h08
`define DPS_A_GEAR_DEN    8'h0C
`define DPS_A_SPSEL       8'h10
`define DPS_A_DSPEED      8'h14
`define DPS_A_ACCEL       8'h18
`define DPS_A_DECEL       8'h1C
`define DPS_A_ARRIVE      8'h20
`define DPS_A_HOMESPD     8'h24
`define DPS_A_CPLHOLD     8'h28
`define DPS_A_RANGE       8'h2C
`define DPS_A_DETECT      8'h30
`define DPS_A_FMAX        8'h34
`define DPS_A_POS_LO      8'h38
`define DPS_A_POS_HI      8'h3C
`define DPS_A_STATUS      8'h40
`define DPS_B_ABS         0
`define DPS_B_AUTO        1
`define DPS_B_REP         2
`define DPS_B_POSVAL      3
`define DPS_B_HOME_EACH   4
`define DPS_B_CAL_ONCE    5
`define DPS_B_CPL_LEVEL   6
`define DPS_B_INIT_MOVE   7
`define DPS_B_EN_LEVEL    8
`define DPS_B_SRC_BUS     9
`define DPS_B_SAVE_CNT    10
`define DPS_RST_MODE      16'h0000
`define DPS_RST_TARGET    16'h0000
`define DPS_RST_GEAR      16'h03E8
`define DPS_RST_SPSEL     3'h0
`define DPS_RST_DSPEED    16'h00C8
`define DPS_RST_RAMP_T    16'h012C
`define DPS_RST_ARRIVE    16'h0064
`define DPS_RST_HOMESPD   16'h00C8
`define DPS_RST_CPLHOLD   16'h00C8
`define DPS_RST_RANGE     16'h000A
`define DPS_RST_DETECT    16'h0064
`define DPS_RST_FMAX      16'h1388
`endif

/* File: verilog/dps_pkg.sv */
// Types of the digital positioning sequencer
`default_nettype none
package dps_pkg;
  typedef enum logic [2:0] {DPS_IDLE, DPS_HOME, DPS_WAIT, DPS_MOVE, DPS_SETTLE, DPS_HOLD} dps_state_t;
endpackage
`default_nettype wire

/* File: dv/dps_motor_model.sv */
// Behavioural motor with encoder and home switch
`timescale 1ns/1ps
`default_nettype none
module dps_motor_model #(
  parameter logic [31:0] START   = 32'h0000_0190,
  parameter logic [31:0] HOME_AT = 32'h0000_0064
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] freq_cmd,
  input  wire logic        dir_rev,
  input  wire logic        motor_run,
  output logic      [31:0] enc_count,
  output logic             home_pin
);
  logic [15:0] acc_reg;
  logic [16:0] sum;
  assign sum = {1'b0, acc_reg} + {1'b0, freq_cmd};
  // One count per 128 units of frequency, so slow speeds still creep
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_reg   <= 16'h0000;
      enc_count <= START;
    end else if (motor_run && sum >= 17'h00080) begin
      acc_reg   <= 16'(sum - 17'h00080);
      enc_count <= dir_rev ? enc_count - 32'h1 : enc_count + 32'h1;
    end else if (motor_run) begin
      acc_reg <= sum[15:0];
    end
  end
  // Switch closed everywhere below the mark
  assign home_pin = $signed(enc_count) <= $signed(HOME_AT);
endmodule
`default_nettype wire

/* File: dv/dps_sequencer_chk.sv */
// Port-level assertions for the positioning sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"
module dps_sequencer_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        run_cmd,
  input wire logic        power_fail_pin,
  input wire logic        orient_done,
  input wire logic [15:0] freq_cmd,
  input wire logic        dir_rev,
  input wire logic        motor_run,
  input wire logic        positioning_done,
  input wire logic        orient_done_out,
  input wire logic        home_found,
  input wire logic        save_req
);
  logic [15:0] mode_q, homespd_q;
  // Shadows of the fields that the properties depend on
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q    <= `DPS_RST_MODE;
      homespd_q <= `DPS_RST_HOMESPD;
    end else if (ce && wr && addr == `DPS_A_MODE) begin
      mode_q <= wdata & `DPS_MODE_MASK;
    end else if (ce && wr && addr == `DPS_A_HOMESPD) begin
      homespd_q <= wdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_rdata_quiet: assert property (ce && !rd |=> rdata == 16'h0000)
    else $error("read data outside a read slot");
  a_mode_resv: assert property (ce && rd && addr == `DPS_A_MODE |=> rdata[15:11] == 5'h00)
    else $error("reserved mode bits read nonzero");
  a_home_reverse: assert property (run_cmd && $past(run_cmd) && $past(run_cmd, 2) && motor_run && !home_found |-> dir_rev)
    else $error("homing not in reverse");
  a_home_speed: assert property (run_cmd && $past(run_cmd) && $past(run_cmd, 2) && motor_run && !home_found |-> freq_cmd == homespd_q)
    else $error("homing speed differs from setting");
  a_found_sticky: assert property (home_found |=> home_found)
    else $error("home flag lost");
  a_save_pulse: assert property (save_req && ce |=> !save_req)
    else $error("save request longer than one cycle");
  a_save_enabled: assert property (save_req |-> mode_q[`DPS_B_SAVE_CNT])
    else $error("save request while saving is off");
  a_save_cause: assert property (save_req |-> $past(power_fail_pin, 3) || $past(power_fail_pin, 4) || $past(power_fail_pin, 5))
    else $error("save request without power failure");
  a_done_cause: assert property ($rose(positioning_done) |-> $past(run_cmd))
    else $error("completion without a run");
  a_stop_clears: assert property ($fell(run_cmd) |-> ##[1:2] !positioning_done)
    else $error("completion kept after stop");
  a_orient_cause: assert property ($rose(orient_done_out) |-> $past(orient_done) || $past(orient_done, 2) || $past(orient_done, 3))
    else $error("orientation output without event");
endmodule
bind dps_sequencer dps_sequencer_chk u_chk (.clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .run_cmd,
  .power_fail_pin, .orient_done, .freq_cmd, .dir_rev, .motor_run, .positioning_done, .orient_done_out,
  .home_found, .save_req);
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the positioning sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dps_params.svh"
module tb_top;
  logic        clk, rst, ce, wr, rd, run_cmd, enable_pin, home_pin, power_fail_pin;
  logic        orient_done, dir_rev, motor_run, save_req, positioning_done, orient_done_out, home_found;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, bus_target, freq_cmd, analog_input_one, analog_input_two;
  logic [15:0] analog_input_three, fast_pulse_input_a, fast_pulse_input_b;
  logic [31:0] enc_count, saved_count;
  int          miscompares, comparisons;
  localparam logic [15:0] RV [14] = '{`DPS_RST_MODE, `DPS_RST_TARGET, `DPS_RST_GEAR, `DPS_RST_GEAR,
    16'(`DPS_RST_SPSEL), `DPS_RST_DSPEED, `DPS_RST_RAMP_T, `DPS_RST_RAMP_T, `DPS_RST_ARRIVE,
    `DPS_RST_HOMESPD, `DPS_RST_CPLHOLD, `DPS_RST_RANGE, `DPS_RST_DETECT, `DPS_RST_FMAX};
  // Refused or clamped writes: address, data, value read back
  localparam logic [7:0] RA [9] = '{8'h00, 8'h08, 8'h0C, 8'h14, 8'h10, 8'h10, 8'h18, 8'h1C, 8'h44};
  localparam logic [15:0] RW [9] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h07D0, 16'h0003, 16'h0007,
    16'h0000, 16'h0000, 16'h1234};
  localparam logic [15:0] RE [9] = '{16'h07FF, 16'h0001, 16'h0001, 16'h03E8, 16'h0003, 16'h0003,
    16'h0001, 16'h0001, 16'h0000};
  // Short ramps and a slow creep keep every move inside the run length
  localparam logic [7:0] SA [8] = '{8'h18, 8'h1C, 8'h14, 8'h2C, 8'h30, 8'h20, 8'h24, 8'h10};
  localparam logic [15:0] SW [8] = '{16'h0001, 16'h0001, 16'h0001, 16'h0064, 16'h0000, 16'h0000,
    16'h0010, 16'h0000};

  dps_sequencer DUT (
    .clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .run_cmd, .enable_pin, .home_pin,
    .power_fail_pin, .enc_count, .bus_target, .analog_input_one, .analog_input_two,
    .analog_input_three, .fast_pulse_input_a, .fast_pulse_input_b, .orient_done, .freq_cmd,
    .dir_rev, .motor_run, .positioning_done, .orient_done_out, .home_found, .save_req, .saved_count
  );
  dps_motor_model MOTOR (.clk, .rst, .freq_cmd, .dir_rev, .motor_run, .enc_count, .home_pin);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  wire logic [2:0] flg = {orient_done_out, positioning_done, home_found};

  task automatic wait_sig(input int s, input int lim);
    for (int n = 0; n < lim && flg[s] !== 1'b1; n++) @(posedge clk);
    chk(32'(flg[s]), 32'h1, "awaited flag");
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [15:0] w, e, input string what);
    logic [15:0] d;
    wr_reg(a, w);
    rd_reg(a, d);
    chk(32'(d), 32'(e), what);
  endtask

  initial begin
    logic [15:0] d;
    logic [31:0] pos;
    int tgt, num, den, travel, diff, n;
    void'($urandom(32'h6DADF527));
    {rst, ce, wr, rd, run_cmd, enable_pin, power_fail_pin, orient_done, addr, wdata} = 32'hC000_0000;
    {bus_target, analog_input_one, analog_input_two, analog_input_three, fast_pulse_input_a,
      fast_pulse_input_b} = {$urandom(), $urandom(), $urandom()};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      rd_reg(8'(4 * i), d);
      chk(32'(d), 32'(RV[i]), "reset value");
    end
    for (int i = 0; i < 9; i++) wr_rd(RA[i], RW[i], RE[i], "refused write");
    for (int s = 0; s < 6; s++) wr_rd(`DPS_A_SPSEL, 16'(s), 16'(s), "speed source");
    repeat (4) begin
      tgt = $urandom_range(65535);
      num = $urandom_range(65535, 1);
      wr_rd(`DPS_A_TARGET, 16'(tgt), 16'(tgt), "target");
      wr_rd(`DPS_A_GEAR_NUM, 16'(num), 16'(num), "numerator");
    end
    ce <= 1'b0;
    wr_reg(`DPS_A_TARGET, 16'h5A5A);
    ce <= 1'b1;
    rd_reg(`DPS_A_TARGET, d);
    chk(32'(d), 32'(tgt), "write while clock held");
    for (int m = 0; m < 2; m++) begin
      wr_reg(`DPS_A_MODE, 16'(m << 10));
      power_fail_pin <= 1'b1;
      n = 0;
      repeat (12) begin
        @(posedge clk);
        if (save_req === 1'b1) begin
          n++;
          pos = saved_count;
        end
      end
      power_fail_pin <= 1'b0;
      chk(32'(n), 32'(m), "save pulses");
    end
    chk(pos, enc_count, "saved count");
    orient_done <= 1'b1;
    @(posedge clk);
    orient_done <= 1'b0;
    wait_sig(2, 8);
    tgt = $urandom_range(200, 100);
    num = $urandom_range(3, 1);
    den = $urandom_range(3, 1);
    travel = tgt * num / den;
    for (int i = 0; i < 8; i++) wr_reg(SA[i], SW[i]);
    wr_reg(`DPS_A_TARGET, 16'(tgt));
    wr_reg(`DPS_A_GEAR_NUM, 16'(num));
    wr_reg(`DPS_A_GEAR_DEN, 16'(den));
    wr_reg(`DPS_A_MODE, 16'h0066);
    run_cmd <= 1'b1;
    wait_sig(0, 8000);
    rd_reg(`DPS_A_STATUS, d);
    chk(32'(d[5]), 32'h1, "home flag in status");
    wait_sig(1, 30000);
    repeat (1000) @(posedge clk);
    chk(32'(positioning_done), 32'h1, "completion held");
    rd_reg(`DPS_A_POS_LO, pos[15:0]);
    rd_reg(`DPS_A_POS_HI, pos[31:16]);
    diff = int'($signed(pos)) - travel;
    chk(32'(diff <= 160 && diff >= -160), 32'h1, "travel reached");
    run_cmd <= 1'b0;
    repeat (3000) @(posedge clk);
    chk(32'(positioning_done), 32'h0, "completion after stop");
    wr_reg(`DPS_A_MODE, 16'h0124);
    run_cmd <= 1'b1;
    repeat (3000) @(posedge clk);
    chk(32'({motor_run, positioning_done}), 32'h0, "idle without enable");
    enable_pin <= 1'b1;
    wait_sig(1, 30000);
    complete_run();
  end
endmodule
`default_nettype wire
